// ==== logic/prs_i2c_slave.sv ====
// Purpose: serial slave serving the frequency and pull-range registers
// Assumes: pins oversampled on clk; osc_clk drives the oscillator core
// Notes: sda is open drain, only ever pulled low
//
// How it works
// - range register bits 15:4 read zero, writes to them dropped
// - range code 0..15 maps to ascending ppm limits
// - range powers up at factory value, writable at any time
// - slave only, oversampling supports 1 Mbit/s
// - sda changes only while scl is low
// - start is sda fall with scl high, stop is sda rise
// - repeated start treated as a fresh start
// - eight bits per byte, msb first, unlimited bytes
// - ninth pulse carries ack, low means ack
// - nack only for a foreign device address
// - master ack on a read byte makes slave release sda
// - master nack on a read byte makes slave send next byte
// - first byte is 7-bit address plus direction, 1 reads
// - one-byte pointer advances after each register access
// - pointer wraps from 255 to 0
// - words are two bytes, upper byte first
// - read starts at current pointer, which resets to 0
// - pull launches a fixed delay after upper word write
// - settled flag rises a fixed time after launch
// - 26-bit word split lower 16 and upper 10, reset zero
// - only an upper word write launches a change
`timescale 1ns/1ns
module prs_i2c_slave
  import prs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter logic [RANGE_W-1:0] FACTORY_RANGE = RANGE_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic osc_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic [RANGE_W-1:0] range_sel,
  output logic [PPM_W-1:0] range_ppm_x100,
  output logic out_en,
  output logic pull_pending,
  output logic pull_settled,
  output logic [FREQ_W-1:0] freq_word
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    prs_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic mack;
    logic hi_sel;
    logic [7:0] hi_byte;
    logic [7:0] ptr;
    logic [WORD_W-1:0] lo;
    logic [UP_W-1:0] up;
    logic oe;
    logic [RANGE_W-1:0] range;
    logic [PPM_W-1:0] ppm;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic dly_run;
    logic [DLY_W-1:0] dly_cnt;
    logic set_run;
    logic [SET_W-1:0] set_cnt;
    logic settled;
    logic [FREQ_W-1:0] stage;
    logic req_tgl;
  } prs_main_s;

  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic rs1;
    logic rs2;
    logic [FREQ_W-1:0] word;
  } prs_osc_s;

  prs_main_s st_r;
  prs_main_s st_nxt;
  prs_osc_s os_r;
  prs_osc_s os_nxt;
  logic scl_f;
  logic sda_f;
  logic ev_rise;
  logic ev_fall;
  logic ev_start;
  logic ev_stop;
  logic [WORD_W-1:0] rd_word;
  logic [7:0] ld_byte;
  logic [WORD_W-1:0] wdata;

  // ----------------------------------------
  // pin capture and bus events
  // ----------------------------------------
  prs_sync u_scl_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(scl_i),
    .filt(scl_f)
  );

  prs_sync u_sda_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(sda_i),
    .filt(sda_f)
  );

  assign ev_rise = scl_f & ~st_r.scl_q;
  assign ev_fall = ~scl_f & st_r.scl_q;
  assign ev_start = scl_f & st_r.scl_q & st_r.sda_q & ~sda_f;
  assign ev_stop = scl_f & st_r.scl_q & ~st_r.sda_q & sda_f;

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  always_comb begin
    case (st_r.ptr)
      REG_LO: rd_word = st_r.lo;
      REG_UP: rd_word = {{(WORD_W-UP_W-1){1'b0}}, st_r.oe, st_r.up};
      REG_RANGE: rd_word = {{(WORD_W-RANGE_W){1'b0}}, st_r.range};
      default: rd_word = '0;
    endcase
  end

  assign ld_byte = st_r.hi_sel ? rd_word[WORD_W-1:8] : rd_word[7:0];
  assign wdata = {st_r.hi_byte, st_r.shreg};

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_comb begin
    logic do_load;
    logic do_wr;
    do_load = 1'b0;
    do_wr = 1'b0;
    st_nxt = st_r;
    st_nxt.scl_q = scl_f;
    st_nxt.sda_q = sda_f;
    if (ev_start) begin
      st_nxt.state = ST_ADDR;
      st_nxt.bitcnt = '0;
      st_nxt.sda_oe = 1'b0;
    end else if (ev_stop) begin
      st_nxt.state = ST_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      case (st_r.state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (ev_rise) begin
            st_nxt.shreg = {st_r.shreg[6:0], sda_f};
            st_nxt.bitcnt = st_r.bitcnt + BIT_ONE;
          end else if (ev_fall && st_r.bitcnt == BIT_FULL) begin
            st_nxt.bitcnt = '0;
            st_nxt.sda_oe = 1'b1;
            if (st_r.state == ST_ADDR) begin
              if (st_r.shreg[7:1] == DEV_ADDR) begin
                st_nxt.rw = st_r.shreg[0];
                st_nxt.hi_sel = 1'b1;
                st_nxt.state = ST_AACK;
              end else begin
                st_nxt.sda_oe = 1'b0;
                st_nxt.state = ST_IDLE;
              end
            end else if (st_r.state == ST_PTR) begin
              st_nxt.ptr = st_r.shreg;
              st_nxt.hi_sel = 1'b1;
              st_nxt.state = ST_PACK;
            end else begin
              st_nxt.state = ST_WACK;
              if (st_r.hi_sel) begin
                st_nxt.hi_byte = st_r.shreg;
                st_nxt.hi_sel = 1'b0;
              end else begin
                do_wr = 1'b1;
                st_nxt.hi_sel = 1'b1;
                st_nxt.ptr = st_r.ptr + PTR_ONE;
              end
            end
          end
        end
        ST_AACK, ST_PACK, ST_WACK: begin
          if (ev_fall) begin
            st_nxt.sda_oe = 1'b0;
            if (st_r.state == ST_AACK && st_r.rw) begin
              do_load = 1'b1;
            end else if (st_r.state == ST_AACK) begin
              st_nxt.state = ST_PTR;
            end else begin
              st_nxt.state = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (ev_fall) begin
            if (st_r.bitcnt == BIT_LAST) begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.bitcnt = '0;
              st_nxt.state = ST_RACK;
            end else begin
              st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
              st_nxt.sda_oe = ~st_r.shreg[6];
              st_nxt.bitcnt = st_r.bitcnt + BIT_ONE;
            end
          end
        end
        ST_RACK: begin
          if (ev_rise) begin
            st_nxt.mack = sda_f;
          end else if (ev_fall) begin
            if (!st_r.mack) begin
              st_nxt.state = ST_IDLE;
            end else begin
              do_load = 1'b1;
            end
          end
        end
        ST_IDLE: begin
          st_nxt.sda_oe = 1'b0;
        end
        default: begin
          st_nxt.state = ST_IDLE;
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    // a zero first bit keeps sda low, blocking stop and start
    if (do_load) begin
      st_nxt.shreg = ld_byte;
      st_nxt.sda_oe = ~ld_byte[7];
      st_nxt.bitcnt = '0;
      st_nxt.state = ST_RDATA;
      st_nxt.hi_sel = ~st_r.hi_sel;
      if (!st_r.hi_sel) begin
        st_nxt.ptr = st_r.ptr + PTR_ONE;
      end
    end
    // frequency launch timers
    if (st_r.dly_run) begin
      st_nxt.dly_cnt = st_r.dly_cnt + 1'b1;
      if (st_r.dly_cnt == FD_LAST) begin
        st_nxt.dly_run = 1'b0;
        st_nxt.stage = {st_r.up, st_r.lo};
        st_nxt.req_tgl = ~st_r.req_tgl;
        st_nxt.set_run = 1'b1;
        st_nxt.set_cnt = '0;
      end
    end
    if (st_r.set_run) begin
      st_nxt.set_cnt = st_r.set_cnt + 1'b1;
      if (st_r.set_cnt == SET_LAST) begin
        st_nxt.set_run = 1'b0;
        st_nxt.settled = 1'b1;
      end
    end
    if (do_wr) begin
      case (st_r.ptr)
        REG_LO: st_nxt.lo = wdata;
        REG_UP: begin
          st_nxt.up = wdata[UP_W-1:0];
          st_nxt.oe = wdata[OE_BIT];
          // a rewrite during the wait restarts it
          st_nxt.dly_run = 1'b1;
          st_nxt.dly_cnt = '0;
          st_nxt.set_run = 1'b0;
          st_nxt.settled = 1'b0;
        end
        REG_RANGE: st_nxt.range = wdata[RANGE_W-1:0];
        default: st_nxt.range = st_r.range;
      endcase
    end
    st_nxt.ppm = prs_range_ppm(st_nxt.range);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.ptr <= PTR_RST;
      st_r.range <= FACTORY_RANGE;
      st_r.ppm <= prs_range_ppm(FACTORY_RANGE);
      st_r.scl_q <= BUS_IDLE;
      st_r.sda_q <= BUS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // oscillator domain
  // ----------------------------------------
  // staging word is loaded with the toggle and held until the next launch, long after the toggle is seen
  always_comb begin
    os_nxt = os_r;
    os_nxt.t1 = st_r.req_tgl;
    os_nxt.t2 = os_r.t1;
    os_nxt.t3 = os_r.t2;
    os_nxt.rs1 = rst_b;
    os_nxt.rs2 = os_r.rs1;
    if (os_r.t2 != os_r.t3) begin
      os_nxt.word = st_r.stage;
    end
  end

  // reset crosses two osc flops, so a reset pulse that spans no osc_clk rising edge is missed
  always_ff @(posedge osc_clk) begin
    if (!os_r.rs2) begin
      os_r <= '0;
      os_r.rs1 <= rst_b;
      os_r.rs2 <= os_r.rs1;
    end else begin
      os_r <= os_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = st_r.sda_oe;
  assign range_sel = st_r.range;
  assign range_ppm_x100 = st_r.ppm;
  assign out_en = st_r.oe;
  assign pull_pending = st_r.dly_run;
  assign pull_settled = st_r.settled;
  assign freq_word = os_r.word;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RANGE_TOP_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.state == ST_RDATA && st_r.ptr == REG_RANGE && !st_r.hi_sel) |-> st_r.sda_oe)
    else $error("range register upper byte not sent as zero");

  AST_PTR_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.state == ST_WDATA && ev_fall && !ev_stop && st_r.bitcnt == BIT_FULL
     && !st_r.hi_sel && st_r.ptr == 8'hFF) |=> (st_r.ptr == 8'h00))
    else $error("pointer did not wrap to zero");

  AST_NACK_FOREIGN: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.state == ST_ADDR && ev_fall && !ev_stop && st_r.bitcnt == BIT_FULL
     && st_r.shreg[7:1] != DEV_ADDR) |=> (!st_r.sda_oe && st_r.state == ST_IDLE))
    else $error("foreign address was acknowledged");

  AST_ACK_OWN: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.state == ST_ADDR && ev_fall && !ev_stop && st_r.bitcnt == BIT_FULL
     && st_r.shreg[7:1] == DEV_ADDR) |=> (st_r.sda_oe && st_r.state == ST_AACK
     && st_r.rw == $past(st_r.shreg[0])))
    else $error("own address not acknowledged");

  AST_START: assert property (@(posedge clk) disable iff (!rst_b)
    ev_start |=> (st_r.state == ST_ADDR && st_r.bitcnt == '0 && !st_r.sda_oe))
    else $error("start not taken");

  AST_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    ev_stop |=> (st_r.state == ST_IDLE && !st_r.sda_oe))
    else $error("stop not taken");

  AST_SDA_LOW_PHASE: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(st_r.sda_oe) |-> (!$past(scl_f) || $past(ev_start) || $past(ev_stop)))
    else $error("sda drive changed while scl high");

  AST_READ_UPPER_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.state == ST_AACK && st_r.rw && ev_fall && !ev_stop)
    |=> (st_r.shreg == $past(rd_word[WORD_W-1:8]) && st_r.state == ST_RDATA))
    else $error("read did not start with upper byte");

  AST_FDELAY_LAUNCH: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.dly_run && st_r.dly_cnt == FD_LAST) |=> ($changed(st_r.req_tgl)
    && st_r.set_run && !st_r.dly_run && st_r.stage == {st_r.up, st_r.lo}))
    else $error("pull not launched at end of delay");

  AST_SETTLE: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.set_run && st_r.set_cnt == SET_LAST && !st_r.dly_run) |=> st_r.settled)
    else $error("settled flag late");
endmodule : prs_i2c_slave

// ==== logic/prs_pkg.sv ====
// Purpose: shared constants and types of the pull-range register slave
// Assumes: 20 MHz system clock
// Notes: times are kept as printed, cycle counts derive from them
package prs_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int FDELAY_NS = 103000;
  localparam int FDELAY_CYC = FDELAY_NS / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 16500;
  localparam int SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
  localparam int DLY_W = 12;
  localparam int SET_W = 9;
  localparam logic [DLY_W-1:0] FD_LAST = DLY_W'(FDELAY_CYC - 1);
  localparam logic [SET_W-1:0] SET_LAST = SET_W'(SETTLE_CYC - 1);
  // ----------------------------------------
  // framing and register map
  // ----------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [7:0] PTR_ONE = 8'h01;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] REG_LO = 8'h00;
  localparam logic [7:0] REG_UP = 8'h01;
  localparam logic [7:0] REG_RANGE = 8'h02;
  localparam int WORD_W = 16;
  localparam int UP_W = 10;
  localparam int OE_BIT = 10;
  localparam int RANGE_W = 4;
  localparam int FREQ_W = 26;
  localparam int PPM_W = 19;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h60;
  // factory value, arbitrary here
  localparam logic [3:0] RANGE_DEF = 4'h0;
  localparam logic BUS_IDLE = 1'b1;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_PTR   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } prs_state_e;

  // pull range in hundredths of a ppm
  function automatic logic [PPM_W-1:0] prs_range_ppm(input logic [RANGE_W-1:0] code);
    case (code)
      4'h0: prs_range_ppm = 19'h00271;
      4'h1: prs_range_ppm = 19'h003E8;
      4'h2: prs_range_ppm = 19'h004E2;
      4'h3: prs_range_ppm = 19'h009C4;
      4'h4: prs_range_ppm = 19'h01388;
      4'h5: prs_range_ppm = 19'h01F40;
      4'h6: prs_range_ppm = 19'h02710;
      4'h7: prs_range_ppm = 19'h030D4;
      4'h8: prs_range_ppm = 19'h03A98;
      4'h9: prs_range_ppm = 19'h04E20;
      4'hA: prs_range_ppm = 19'h09C40;
      4'hB: prs_range_ppm = 19'h0EA60;
      4'hC: prs_range_ppm = 19'h13880;
      4'hD: prs_range_ppm = 19'h1D4C0;
      4'hE: prs_range_ppm = 19'h27100;
      default: prs_range_ppm = 19'h4E200;
    endcase
  endfunction : prs_range_ppm
endpackage : prs_pkg

// ==== logic/prs_sync.sv ====
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: pin idles high
// Notes: output moves only when second and third stage agree
`timescale 1ns/1ns
module prs_sync
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic filt
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
  } prs_sync_s;

  prs_sync_s st_r;
  prs_sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.f = st_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '{BUS_IDLE, BUS_IDLE, BUS_IDLE, BUS_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filt = st_r.f;
endmodule : prs_sync

// ==== testbench/prs_i2c_slave_bench.sv ====
// Purpose: self-checking bench of the pull-range register slave
// Assumes: master model on the serial pins, default device address
// Notes: pull timing measured by edge watchers on the status outputs
`timescale 1ns/1ns
module prs_i2c_slave_bench
  import prs_pkg::*;
;
  // ----------------------------------------
  // setup
  // ----------------------------------------
  localparam logic [3:0] FACT = 4'h5;
  localparam int LIMIT = 60000;
  localparam logic [PPM_W-1:0] PPM_TAB [16] = '{19'h00271, 19'h003E8, 19'h004E2, 19'h009C4, 19'h01388,
    19'h01F40, 19'h02710, 19'h030D4, 19'h03A98, 19'h04E20, 19'h09C40, 19'h0EA60, 19'h13880, 19'h1D4C0,
    19'h27100, 19'h4E200};
  logic clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst_b = 1'b0;
  logic m_scl, m_sda, sda_w, sda_o, sda_oe, out_en, pull_pending, pull_settled, pp_q, ps_q;
  logic [RANGE_W-1:0] range_sel;
  logic [PPM_W-1:0] range_ppm_x100;
  logic [FREQ_W-1:0] freq_word;
  logic [15:0] got [0:3];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_rise = 0;
  int t_fall = 0;
  int t_set = 0;
  always #25 clk = ~clk;
  // unrelated phase to clk
  initial begin
    #17;
    forever begin
      #62 osc_clk = 1'b1;
      #63 osc_clk = 1'b0;
    end
  end
  assign sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
  prs_master prs_master_inst (.clk(clk), .sda_w(sda_w), .scl(m_scl), .sda(m_sda));
  prs_i2c_slave #(.DEV_ADDR(DEV_ADDR_DEF), .FACTORY_RANGE(FACT)) prs_i2c_slave_inst (
    .clk(clk), .rst_b(rst_b), .osc_clk(osc_clk), .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .range_sel(range_sel), .range_ppm_x100(range_ppm_x100), .out_en(out_en),
    .pull_pending(pull_pending), .pull_settled(pull_settled), .freq_word(freq_word));
  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_val(input string nm, input logic [25:0] e, input logic [25:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // cycle count, pull timing capture and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pp_q <= pull_pending;
    ps_q <= pull_settled;
    if (pull_pending === 1'b1 && pp_q === 1'b0) t_rise <= cyc;
    if (pull_pending === 1'b0 && pp_q === 1'b1) t_fall <= cyc;
    if (pull_settled === 1'b1 && ps_q === 1'b0) t_set <= cyc;
    if (cyc == LIMIT) begin
      fails++;
      $display("BAD timeout expected done seen hang");
      final_report();
    end
  end
  // ----------------------------------------
  // register access
  // ----------------------------------------
  task automatic addr(input logic rd);
    logic a;
    prs_master_inst.start();
    prs_master_inst.send({DEV_ADDR_DEF, rd}, a);
    chk_bit("addr ack", 1'b1, a);
  endtask : addr
  // n words from ptr; one or two
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w0, input logic [15:0] w1, input int n);
    logic a;
    logic [15:0] w;
    addr(1'b0);
    prs_master_inst.send(ptr, a);
    chk_bit("ptr ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      w = (i == 0) ? w0 : w1;
      prs_master_inst.send(w[15:8], a);
      chk_bit("hi ack", 1'b1, a);
      prs_master_inst.send(w[7:0], a);
      chk_bit("lo ack", 1'b1, a);
    end
    prs_master_inst.stop();
  endtask : wr
  // without setp the read starts where the pointer stands
  task automatic rd(input logic setp, input logic [7:0] ptr, input int n);
    logic a;
    logic [7:0] hi;
    logic [7:0] lo;
    if (setp) begin
      addr(1'b0);
      prs_master_inst.send(ptr, a);
      chk_bit("ptr ack", 1'b1, a);
    end
    addr(1'b1);
    for (int i = 0; i < n; i++) begin
      prs_master_inst.recv(1'b0, hi);
      prs_master_inst.recv(i == n - 1, lo);
      got[i] = {hi, lo};
    end
    prs_master_inst.stop();
  endtask : rd
  task automatic end_test(input string nm);
    $display("test %s done, checks %0d mismatches %0d", nm, n_tests, fails);
  endtask : end_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic a;
    // oscillator side takes the reset through its own two flops
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    chk_val("range_sel", FACT, range_sel);
    chk_val("range_ppm", 19'h01F40, range_ppm_x100);
    chk_val("freq_word", 26'h0, freq_word);
    chk_bit("out_en", 1'b0, out_en);
    chk_bit("sda_oe", 1'b0, sda_oe);
    rd(1'b0, 8'h00, 3);
    chk_val("reg00", 16'h0000, got[0]);
    chk_val("reg01", 16'h0000, got[1]);
    chk_val("reg02", {12'h000, FACT}, got[2]);
    end_test("reset");
    for (int c = 0; c < 16; c++) begin
      wr(REG_RANGE, 16'hFFF0 | 16'(c), 16'h0000, 1);
      rd(1'b1, REG_RANGE, 1);
      chk_val("range_sel", 26'(c), range_sel);
      chk_val("range_ppm", PPM_TAB[c], range_ppm_x100);
      chk_val("reg02", 26'(c), got[0]);
    end
    end_test("range");
    wr(REG_LO, 16'h1234, 16'hFFFF, 2);
    chk_bit("pending", 1'b1, pull_pending);
    chk_val("freq_word early", 26'h0, freq_word);
    chk_bit("out_en", 1'b1, out_en);
    for (int k = 0; k < 3000 && pull_settled !== 1'b1; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk_val("delay", 26'(FDELAY_CYC), 26'(t_fall - t_rise));
    chk_bit("delay max", 1'b1, (t_fall - t_rise) <= 2800);
    chk_val("settle", 26'(SETTLE_CYC), 26'(t_set - t_fall));
    chk_bit("settle max", 1'b1, (t_set - t_fall) <= 400);
    chk_val("freq_word", {10'h3FF, 16'h1234}, freq_word);
    rd(1'b1, REG_LO, 2);
    chk_val("reg00", 16'h1234, got[0]);
    chk_val("reg01", 16'h07FF, got[1]);
    end_test("freq");
    // lower word alone must not launch a change
    wr(REG_LO, 16'h0001, 16'h0000, 1);
    repeat (40) @(posedge clk);
    chk_bit("pending lower", 1'b0, pull_pending);
    chk_bit("settled kept", 1'b1, pull_settled);
    chk_val("freq_word kept", {10'h3FF, 16'h1234}, freq_word);
    end_test("lower");
    wr(8'hFF, 16'hBEEF, 16'hABCD, 2);
    rd(1'b0, 8'h00, 1);
    chk_val("reg01 after wrap", 16'h07FF, got[0]);
    rd(1'b1, 8'hFF, 2);
    chk_val("reg ff", 16'h0000, got[0]);
    chk_val("reg00 wrapped", 16'hABCD, got[1]);
    end_test("wrap");
    prs_master_inst.start();
    prs_master_inst.send({DEV_ADDR_DEF ^ 7'h01, 1'b0}, a);
    chk_bit("foreign ack", 1'b0, a);
    prs_master_inst.send(REG_RANGE, a);
    chk_bit("ignored ack", 1'b0, a);
    prs_master_inst.stop();
    chk_val("range kept", 26'h00000F, range_sel);
    end_test("foreign");
    final_report();
  end
endmodule : prs_i2c_slave_bench

// ==== testbench/prs_master.sv ====
// Purpose: bus master model driving the serial clock and data lines
// Assumes: wire resolved in the bench, both lines pulled up
// Notes: every move lands just after a clk rising edge
`timescale 1ns/1ns
module prs_master
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  // ----------------------------------------
  // timing
  // ----------------------------------------
  // half scl period in clk cycles, kept above the slave's sampling floor
  localparam int HALF = 10;
  initial begin
    scl = BUS_IDLE;
    sda = BUS_IDLE;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // ----------------------------------------
  // bus primitives
  // ----------------------------------------
  // data moves two clk after scl falls so no false start is seen
  task automatic bit_xfer(input logic b, output logic r);
    wt(2);
    sda <= b;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    r = sda_w;
    scl <= 1'b0;
  endtask : bit_xfer
  // also serves as repeated start
  task automatic start();
    wt(2);
    sda <= 1'b1;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda <= 1'b0;
    wt(HALF);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    wt(2);
    sda <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda <= 1'b1;
    wt(HALF);
  endtask : stop
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic m_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~m_ack, r);
  endtask : recv
endmodule : prs_master
